// file: lba_defs.svh
/*
  register offsets, reset values, field positions and timing counts of the
  leaky-bucket activity alarm. assumes inclusion by bare name.
*/
`ifndef LBA_DEFS_SVH
`define LBA_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LBA_OFF_SET_LIMIT   8'h00
`define LBA_OFF_CLR_LIMIT   8'h01
`define LBA_OFF_DECAY       8'h02
`define LBA_OFF_BUCKET_SIZE 8'h03
`define LBA_OFF_STATUS      8'h04
`define LBA_OFF_IRQ_STAT    8'h05
`define LBA_OFF_IRQ_MASK    8'h06
`define LBA_OFF_LEVEL       8'h07

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LBA_RST_SET_LIMIT   8'h06
`define LBA_RST_CLR_LIMIT   8'h00
`define LBA_RST_DECAY       2'h1
`define LBA_RST_BUCKET_SIZE 8'h08
`define LBA_RST_IRQ_MASK    2'h0

// ----------------------------------------------------------------
// interrupt field positions
// ----------------------------------------------------------------
`define LBA_IRQ_RAISE 0
`define LBA_IRQ_CLEAR 1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LBA_CYCLE_MS 128
`define LBA_CLK_HZ   25000000

`endif

// file: lba_pkg.sv
/*
  types of the leaky-bucket activity alarm.
  assumes nothing of its surroundings.
*/
package lba_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [7:0] lba_byte_t;
  typedef logic [1:0] lba_decay_t;

endpackage : lba_pkg

// file: lba_tick_if.sv
/*
  interface carrying the observation-cycle tick between the timebase
  and the bucket logic. assumes one clock domain.
*/
`timescale 1ns/1ps
interface lba_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface : lba_tick_if

// file: lba_timebase.sv
/*
  observation-cycle timebase: one-cycle tick every period_cycles clocks.
  assumes a free-running mclk and synchronous active-high srst.
*/
`timescale 1ns/1ps
module lba_timebase #(
  parameter int unsigned PERIOD_CYCLES = 3200000
) (
  input  wire logic mclk,
  input  wire logic srst,
  lba_tick_if.src   tick_o
);

  // ----------------------------------------------------------------
  // period counter
  // ----------------------------------------------------------------
  logic [31:0] cnt_q;

  // count up, tick on wrap
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q       <= 32'h0;
      tick_o.tick <= 1'b0;
    end else if (cnt_q == PERIOD_CYCLES - 1) begin
      cnt_q       <= 32'h0;
      tick_o.tick <= 1'b1;
    end else begin
      cnt_q       <= cnt_q + 32'h1;
      tick_o.tick <= 1'b0;
    end
  end

endmodule : lba_timebase

// file: lba_bucket.sv
/*
  leaky-bucket activity alarm for one bucket configuration, with its
  register port and interrupt. assumes inputs synchronous to mclk and a
  master that never drives both strobes at once.
*/
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "lba_defs.svh"

// Notes on behaviour
// - input judged failed or erratic over each fixed 128 ms observation cycle
// - each faulty observation cycle adds one to the accumulator
// - each clean stretch of 1, 2, 4 or 8 cycles subtracts one
// - alarm raised when accumulator reaches upper limit, reset value 0x06
// - alarm cleared when accumulator falls to the lower limit
// - accumulator capped at programmable bucket size, default 0x08
module lba_bucket
  import lba_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = (`LBA_CLK_HZ / 1000) * `LBA_CYCLE_MS
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       fault_in,
  input  wire logic [7:0] reg_addr,
  input  lba_pkg::lba_byte_t reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output lba_pkg::lba_byte_t reg_rdata,
  output logic            alarm,
  output logic            irq
);
  import lba_pkg::*;

  // ----------------------------------------------------------------
  // observation timebase
  // ----------------------------------------------------------------
  lba_tick_if tick_bus ();

  lba_timebase #(
    .PERIOD_CYCLES (PERIOD_CYCLES)
  ) u_timebase (
    .mclk   (mclk),
    .srst   (srst),
    .tick_o (tick_bus)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  lba_byte_t  set_limit_q;
  lba_byte_t  clr_limit_q;
  lba_decay_t decay_q;
  lba_byte_t  bucket_size_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_stat_q;
  lba_byte_t  level_q;
  logic       fault_seen_q;
  logic [2:0] clean_q;
  logic       alarm_q;
  logic       irq_q;

  // software-written configuration
  always_ff @(posedge mclk) begin
    if (srst) begin
      set_limit_q   <= `LBA_RST_SET_LIMIT;
      clr_limit_q   <= `LBA_RST_CLR_LIMIT;
      decay_q       <= `LBA_RST_DECAY;
      bucket_size_q <= `LBA_RST_BUCKET_SIZE;
      irq_mask_q    <= `LBA_RST_IRQ_MASK;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `LBA_OFF_SET_LIMIT:   set_limit_q   <= reg_wdata;
        `LBA_OFF_CLR_LIMIT:   clr_limit_q   <= reg_wdata;
        `LBA_OFF_DECAY:       decay_q       <= reg_wdata[1:0];
        `LBA_OFF_BUCKET_SIZE: bucket_size_q <= reg_wdata;
        `LBA_OFF_IRQ_MASK:    irq_mask_q    <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // fault capture within the observation cycle
  // ----------------------------------------------------------------
  // sticky until the cycle ends; a fault on the tick counts for next cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      fault_seen_q <= 1'b0;
    end else if (tick_bus.tick) begin
      fault_seen_q <= fault_in;
    end else if (fault_in) begin
      fault_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  logic [3:0] clean_len;
  assign clean_len = 4'h1 << decay_q; // 1, 2, 4 or 8 cycles

  // fill on faulty cycle, leak after a clean stretch
  always_ff @(posedge mclk) begin
    if (srst) begin
      level_q <= 8'h00;
      clean_q <= 3'h0;
    end else if (tick_bus.tick) begin
      if (fault_seen_q) begin
        clean_q <= 3'h0;
        if (level_q < bucket_size_q) begin
          level_q <= level_q + 8'h01;
        end
      end else if ({1'b0, clean_q} + 4'h1 >= clean_len) begin
        clean_q <= 3'h0;
        if (level_q != 8'h00) begin
          level_q <= level_q - 8'h01;
        end
      end else begin
        clean_q <= clean_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // alarm with hysteresis
  // ----------------------------------------------------------------
  logic raise_ev;
  logic clear_ev;
  assign raise_ev = !alarm_q && (level_q >= set_limit_q);
  assign clear_ev = alarm_q && (level_q <= clr_limit_q);

  // set at upper limit, cleared at lower limit
  always_ff @(posedge mclk) begin
    if (srst) begin
      alarm_q <= 1'b0;
    end else if (raise_ev) begin
      alarm_q <= 1'b1;
    end else if (clear_ev) begin
      alarm_q <= 1'b0;
    end
  end
  assign alarm = alarm_q;

  // ----------------------------------------------------------------
  // interrupt status and output
  // ----------------------------------------------------------------
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  assign irq_set = {clear_ev, raise_ev};
  assign irq_clr = (reg_wr && reg_addr == `LBA_OFF_IRQ_STAT) ? reg_wdata[1:0] : 2'h0;

  // mask as it stands after this edge, so irq never lags a mask write
  logic [1:0] irq_mask_d;
  assign irq_mask_d = (reg_wr && reg_addr == `LBA_OFF_IRQ_MASK) ? reg_wdata[1:0] : irq_mask_q;

  // write one to clear; a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat_q <= 2'h0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_q      <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_d);
    end
  end
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // data valid the cycle after the read strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `LBA_OFF_SET_LIMIT:   reg_rdata <= set_limit_q;
        `LBA_OFF_CLR_LIMIT:   reg_rdata <= clr_limit_q;
        `LBA_OFF_DECAY:       reg_rdata <= {6'h00, decay_q};
        `LBA_OFF_BUCKET_SIZE: reg_rdata <= bucket_size_q;
        `LBA_OFF_STATUS:      reg_rdata <= {7'h00, alarm_q};
        `LBA_OFF_IRQ_STAT:    reg_rdata <= {6'h00, irq_stat_q};
        `LBA_OFF_IRQ_MASK:    reg_rdata <= {6'h00, irq_mask_q};
        `LBA_OFF_LEVEL:       reg_rdata <= level_q;
        default:              reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : lba_bucket

// file: lba_bucket_asserts.sv
/* port checker for lba_bucket; bound to it at the foot of this file */
`timescale 1ns/1ps
module lba_chk
  import lba_pkg::*;
#(parameter int unsigned PERIOD_CYCLES = 20)
(
  input wire logic    mclk,
  input wire logic    srst,
  input wire logic    fault_in,
  input wire logic    reg_wr,
  input wire logic    reg_rd,
  input lba_pkg::lba_byte_t reg_rdata,
  input wire logic    alarm,
  input wire logic    irq
);
  int unsigned idle_q; // cycles since last fault
  always_ff @(posedge mclk) idle_q <= (srst || fault_in) ? 0 : idle_q + 1;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  chk_alarm_cause: assert property ($rose(alarm) |-> idle_q <= PERIOD_CYCLES + 3)
    else $error("alarm rose without recent fault");
  chk_alarm_clean: assert property ($fell(alarm) |-> $past(idle_q, 2) >= PERIOD_CYCLES)
    else $error("alarm fell without clean cycle");
  chk_alarm_hold: assert property ($changed(alarm) |=> $stable(alarm) [*8])
    else $error("alarm moved between ticks");
  chk_irq_rise: assert property ($rose(irq) |-> $changed(alarm) || $past(reg_wr))
    else $error("irq rose without event");
  chk_irq_fall: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("irq fell without write");
  chk_reset_quiet: assert property (disable iff (1'b0) srst |=> !alarm && !irq && reg_rdata == 8'h00)
    else $error("outputs active after reset");
  cov_raise: cover property ($rose(alarm));
  cov_clear: cover property ($fell(alarm));
  cov_ack: cover property ($fell(irq));
endmodule : lba_chk
bind lba_bucket lba_chk #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_chk (.mclk(mclk), .srst(srst),
  .fault_in(fault_in), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .alarm(alarm), .irq(irq));

// file: testbench.sv
/* self-checking bench for lba_bucket; assumes a 20-clock observation cycle */
`timescale 1ns/1ps
module testbench;
  import lba_pkg::*;
  localparam int P = 20;
  logic      mclk = 0, srst = 1, fault_in = 0, reg_wr = 0, reg_rd = 0, exp_alarm = 0;
  logic [7:0] reg_addr = 0, rd_val;
  lba_byte_t reg_wdata = 0, reg_rdata;
  logic      alarm, irq;
  int        errors = 0, check_count = 0, cyc = 0;
  always #20 mclk = ~mclk;
  lba_bucket #(.PERIOD_CYCLES(P)) dut (.mclk(mclk), .srst(srst), .fault_in(fault_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .alarm(alarm), .irq(irq));
  task automatic finish_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle bus strobes, two edges each
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 0;
    #1 rd_val = reg_rdata;
  endtask : rd
  // k cycles on, read level and alarm
  task automatic step(input int k, input int lvl);
    repeat (k * P - 2) @(posedge mclk);
    rd(8'h07);
    chk("level", lvl[7:0], rd_val);
    if (lvl >= 6) exp_alarm = 1;
    else if (lvl <= 2) exp_alarm = 0;
    chk("alarm", {7'h00, exp_alarm}, {7'h00, alarm});
  endtask : step
  task automatic t_reset_regs;
    rd(8'h00);
    chk("set_limit", 8'h06, rd_val);
    rd(8'h03);
    chk("bucket_size", 8'h08, rd_val);
    rd(8'h02);
    chk("decay", 8'h01, rd_val);
    rd(8'h06);
    chk("irq_mask", 8'h00, rd_val);
    rd(8'h09);
    chk("unmapped", 8'h00, rd_val);
    wr(8'h01, 8'h02);
    rd(8'h01);
    chk("clear_limit", 8'h02, rd_val);
  endtask : t_reset_regs
  // faults every cycle: count up to the cap
  task automatic t_fill;
    wr(8'h06, 8'h01);
    fault_in <= 1;
    rd_val = 0;
    for (int i = 0; i < 60 && rd_val !== 8'h01; i++) rd(8'h07);
    chk("first level", 8'h01, rd_val);
    for (int i = 2; i <= 10; i++) step(1, (i > 8) ? 8 : i);
    chk("irq raise", 8'h01, {7'h00, irq});
    wr(8'h05, 8'h01);
    rd(8'h04);
    chk("status raised", 8'h01, rd_val);
    chk("irq ack", 8'h00, {7'h00, irq});
  endtask : t_fill
  // every decay code, then drain to zero
  task automatic t_decay;
    for (int c = 3; c >= 0; c--) begin
      wr(8'h02, c[7:0]);
      fault_in <= 0;
      repeat ((1 << c) * P - 4) @(posedge mclk);
      rd(8'h07);
      chk("level held", 8'h08, rd_val);
      step(1, 7);
      if (c > 0) begin
        fault_in <= 1;
        step(1, 8);
      end
    end
    for (int l = 6; l >= 0; l--) step(1, l);
    step(2, 0);
  endtask : t_decay
  task automatic t_irq;
    rd(8'h05);
    chk("irq status", 8'h02, rd_val);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(8'h06, 8'h03);
    rd(8'h04);
    chk("irq unmasked", 8'h01, {7'h00, irq});
    wr(8'h05, 8'h02);
    rd(8'h04);
    chk("status cleared", 8'h00, rd_val);
    chk("irq cleared", 8'h00, {7'h00, irq});
  endtask : t_irq
  // smaller programmed cap stops the fill early
  task automatic t_cap;
    wr(8'h03, 8'h03);
    rd(8'h03);
    chk("bucket_size", 8'h03, rd_val);
    fault_in <= 1;
    repeat (5 * P) @(posedge mclk);
    rd(8'h07);
    chk("capped level", 8'h03, rd_val);
  endtask : t_cap
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 0;
    t_reset_regs();
    t_fill();
    t_decay();
    t_irq();
    t_cap();
    finish_test();
  end
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      finish_test();
    end
  end
endmodule : testbench
